// ---- rtl/instruction_prefetch_branch_predict.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [RULE1] buffer holds at most four instructions
// [RULE2] fetch up to twice the issue rate
// [RULE3] 64-bit fetch, two words per doubleword
// [RULE4] taken prediction redirects fetch to target
// [RULE5] not-taken branch dropped, target kept
// [RULE6] static: backward taken, forward not taken
// [RULE7] predict only while enable bit set
// [RULE8] call overwrites single return entry
// [RULE9] every detected conditional branch predicted; code issues conditional calls unpredicted
// [RULE10] speculative misses wait for confirmation
// [RULE11] folded branch leaves no empty slot
// [RULE12] branch condition rides folded instruction
// [RULE13] flush on redirects from the core
// [RULE14] predicted branch and return never flush
// [RULE15] mispredict costs four empty execute cycles
// [RULE16] unpredicted not-taken branch adds nothing
// [RULE17] mispredict cancels all later instructions
// [RULE18] refetch cycles two-three, issue four
// [RULE19] leaf returns use return entry
// [RULE20] return state checked, mismatch flushes
// [RULE21] branch after predicted branch unpredicted
// [RULE22] forward needs preceding instruction buffered
// [RULE23] no prediction on abort or breakpoint
// [RULE24] full buffer holds off fetch requests
module instruction_prefetch_branch_predict #(
  parameter logic [31:0] RESET_PC = pfu_pkg::RESET_PC,
  parameter int unsigned DEPTH    = pfu_pkg::BUF_DEPTH
) (
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  // control from the core
  input  wire logic                   predict_enable_i,
  input  wire logic                   code_state_i,
  // instruction memory
  output logic                        fetch_req_o,
  output logic [31:0]                 fetch_addr_o,
  output logic                        fetch_spec_o,
  input  wire logic                   fetch_valid_i,
  input  wire pfu_pkg::fetch_resp_type fetch_resp_i,
  // issue to the integer unit
  output logic                        issue_valid_o,
  output pfu_pkg::buf_entry_type      issue_entry_o,
  input  wire logic                   issue_ready_i,
  // redirect, resolution and return check
  input  wire logic                   flush_i,
  input  wire logic [31:0]            flush_addr_i,
  input  wire logic                   resolve_i,
  input  wire logic                   ret_check_i,
  input  wire logic [31:0]            link_value_i,
  input  wire logic                   link_state_i,
  output logic                        mispredict_o
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_branch(input logic [31:0] w);
    return (w & pfu_pkg::BRANCH_MASK) == pfu_pkg::BRANCH_MATCH;
  endfunction

  function automatic logic is_return(input logic [31:0] w);
    return ((w & pfu_pkg::RETURN_MASK) == pfu_pkg::EXCH_RET_MATCH) ||
           ((w & pfu_pkg::RETURN_MASK) == pfu_pkg::MOVE_RET_MATCH);
  endfunction

  function automatic logic [31:0] target_of(input logic [31:0] pc,
                                            input logic [31:0] w);
    return pc + pfu_pkg::PC_AHEAD + {{6{w[23]}}, w[23:0], 2'b00};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  pfu_pkg::fetch_state_type state;
  pfu_pkg::buf_entry_type   q_in [2];
  pfu_pkg::buf_entry_type   ent;
  logic [31:0] resp_pc;
  logic        inflight;
  logic        drop;
  logic [31:0] ret_addr;
  logic        ret_state;
  logic        ret_valid;
  logic        prev_branch;
  logic        pend_valid;
  logic [3:0]  pend_cond;
  logic        pend_taken;
  logic [31:0] pend_alt;
  logic [2:0]  q_count;
  logic        q_ready;
  logic [1:0]  push_mask;
  logic        pred_redirect;
  logic [31:0] pred_target;
  logic        pred_spec;
  logic        link_write;
  logic [31:0] link_pc;
  logic        next_prev_branch;
  logic        next_pend_valid;
  logic [3:0]  next_pend_cond;
  logic        next_pend_taken;
  logic [31:0] next_pend_alt;
  logic        ret_mismatch;
  logic        flush_all;
  logic [31:0] flush_pc;
  logic        resp_live;
  logic        rewind;
  logic        room;

  // redirect causes and their priority
  assign ret_mismatch = ret_check_i && (!ret_valid ||
                        link_value_i != ret_addr ||
                        link_state_i != ret_state); // RULE20
  assign flush_all = flush_i | ret_mismatch; // RULE13
  assign flush_pc  = flush_i ? flush_addr_i : link_value_i;
  assign resp_live = fetch_valid_i && inflight && !drop && !flush_all &&
                     !fetch_resp_i.miss && q_ready;
  assign rewind    = fetch_valid_i && inflight && !drop && !flush_all &&
                     (fetch_resp_i.miss || !q_ready);
  assign room      = (q_count < 3'(DEPTH)); // RULE24

  // ----------------------------------------
  // scan of an arriving doubleword
  // ----------------------------------------
  always_comb begin
    logic [31:0] w;
    logic [31:0] pc;
    logic        live;
    logic        ok;
    logic        uncond;
    logic        fwd_ok;
    int unsigned n;
    live = resp_live;
    n = 0;
    w = '0;
    pc = '0;
    ok = 1'b0;
    uncond = 1'b0;
    fwd_ok = 1'b0;
    ent = '0;
    push_mask = '0;
    q_in[0] = '0;
    q_in[1] = '0;
    pred_redirect = 1'b0;
    pred_target = '0;
    pred_spec = 1'b0;
    link_write = 1'b0;
    link_pc = '0;
    next_prev_branch = prev_branch;
    next_pend_valid = pend_valid;
    next_pend_cond = pend_cond;
    next_pend_taken = pend_taken;
    next_pend_alt = pend_alt;
    for (int i = 0; i < 2; i++) begin
      w = fetch_resp_i.data[i*32 +: 32]; // RULE3
      pc = {resp_pc[31:3], (i == 1), 2'b00};
      if (live && (i == 1 || !resp_pc[2])) begin
        uncond = (w[31:28] == pfu_pkg::COND_ALWAYS);
        ok = predict_enable_i && !fetch_resp_i.abort &&
             !fetch_resp_i.bkpt[i] && !next_prev_branch; // RULE7 RULE23 RULE21
        fwd_ok = (i == 1 && !resp_pc[2]) || q_count != '0; // RULE22
        ent = '{instr: w, pc: pc, kind: pfu_pkg::KIND_PLAIN,
                abort: fetch_resp_i.abort, phantom: next_pend_valid,
                phantom_cond: next_pend_cond,
                pred_taken: next_pend_taken, alt_pc: next_pend_alt};
        next_prev_branch = ok && (is_branch(w) || is_return(w));
        if (ok && is_branch(w) && w[pfu_pkg::LINK_BIT] && uncond) begin
          // call: link part issued, branch part taken
          ent.kind = pfu_pkg::KIND_LINK;
          link_write = 1'b1;
          link_pc = pc + pfu_pkg::WORD_STEP; // RULE8
          pred_redirect = 1'b1;
          pred_target = target_of(pc, w); // RULE4
          live = 1'b0;
        end else if (ok && is_return(w) && uncond) begin
          ent.kind = pfu_pkg::KIND_RETURN;
          ent.alt_pc = ret_addr;
          pred_redirect = 1'b1;
          pred_target = ret_addr; // RULE19 RULE14
          live = 1'b0;
        end else if (ok && is_branch(w) && !w[pfu_pkg::LINK_BIT] &&
                     (uncond || w[pfu_pkg::SIGN_BIT])) begin
          // taken: fold onto first target word
          next_pend_valid = 1'b1; // RULE11
          next_pend_cond = w[31:28]; // RULE12
          next_pend_taken = 1'b1;
          next_pend_alt = pc + pfu_pkg::WORD_STEP;
          pred_redirect = 1'b1;
          pred_target = target_of(pc, w); // RULE4 RULE6 RULE9
          pred_spec = !uncond;
          live = 1'b0;
        end else if (ok && is_branch(w) && !w[pfu_pkg::LINK_BIT] &&
                     fwd_ok) begin
          // not taken: removed, target kept for recovery
          next_pend_valid = 1'b1; // RULE5 RULE6
          next_pend_cond = w[31:28];
          next_pend_taken = 1'b0;
          next_pend_alt = target_of(pc, w);
        end
        if (ent.kind != pfu_pkg::KIND_PLAIN || !next_prev_branch ||
            !ok || (is_branch(w) && w[pfu_pkg::LINK_BIT])) begin
          if (!(next_pend_valid && ent.phantom == 1'b0 &&
                next_pend_alt != pend_alt && !is_return(w) &&
                ent.kind == pfu_pkg::KIND_PLAIN && next_prev_branch)) begin
            q_in[n] = ent;
            push_mask[n] = 1'b1;
            n = n + 1;
            next_pend_valid = 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // fetch address and request sequencing
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      fetch_addr_o <= RESET_PC;
      fetch_req_o  <= 1'b0;
      fetch_spec_o <= 1'b0;
      state        <= pfu_pkg::FETCH_RETRY;
      drop         <= 1'b0;
    end else if (flush_all) begin
      fetch_addr_o <= flush_pc; // RULE13 RULE17 RULE18
      fetch_req_o  <= 1'b1;
      fetch_spec_o <= 1'b0;
      state        <= pfu_pkg::FETCH_RUN;
      drop         <= fetch_req_o;
    end else if (pred_redirect) begin
      fetch_addr_o <= pred_target; // RULE14
      fetch_req_o  <= room;
      fetch_spec_o <= pred_spec | (fetch_spec_o & !resolve_i);
      drop         <= fetch_req_o;
    end else if (rewind) begin
      fetch_addr_o <= resp_pc;
      drop         <= fetch_req_o;
      if (fetch_resp_i.miss && fetch_spec_o && !resolve_i) begin
        state       <= pfu_pkg::FETCH_HOLD; // RULE10
        fetch_req_o <= 1'b0;
      end else begin
        fetch_req_o  <= room;
        fetch_spec_o <= fetch_spec_o & !resolve_i;
      end
    end else begin
      drop <= 1'b0;
      case (state)
        pfu_pkg::FETCH_RUN: begin
          if (fetch_req_o)
            fetch_addr_o <= {fetch_addr_o[31:3], 3'b000} +
                            pfu_pkg::DWORD_STEP; // RULE2
          fetch_req_o  <= room; // RULE24
          fetch_spec_o <= fetch_spec_o & !resolve_i;
        end
        pfu_pkg::FETCH_HOLD: begin
          if (resolve_i) begin
            state        <= pfu_pkg::FETCH_RETRY; // RULE10
            fetch_spec_o <= 1'b0;
          end
        end
        default: begin
          state       <= pfu_pkg::FETCH_RUN;
          fetch_req_o <= room;
        end
      endcase
    end
  end

  // response tracking
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      inflight <= 1'b0;
      resp_pc  <= '0;
    end else begin
      inflight <= fetch_req_o;
      resp_pc  <= fetch_addr_o;
    end
  end

  // ----------------------------------------
  // return entry, phantom, mispredict
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ret_addr  <= '0;
      ret_state <= 1'b0;
      ret_valid <= 1'b0;
    end else if (link_write && !flush_all) begin
      ret_addr  <= link_pc; // RULE8 RULE20
      ret_state <= code_state_i;
      ret_valid <= 1'b1;
    end
  end

  // pending phantom and branch adjacency
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || flush_all) begin
      prev_branch <= 1'b0; // RULE17
      pend_valid  <= 1'b0;
      pend_cond   <= '0;
      pend_taken  <= 1'b0;
      pend_alt    <= '0;
    end else if (resp_live) begin
      prev_branch <= next_prev_branch; // RULE21
      pend_valid  <= next_pend_valid;
      pend_cond   <= next_pend_cond;
      pend_taken  <= next_pend_taken;
      pend_alt    <= next_pend_alt;
    end
  end

  // one pulse per failed return check
  always_ff @(posedge mclk_i) begin
    if (!resetn_i)
      mispredict_o <= 1'b0;
    else
      mispredict_o <= ret_mismatch; // RULE20
  end

  // ----------------------------------------
  // buffer
  // ----------------------------------------
  prefetch_queue #(
    .WIDTH ($bits(pfu_pkg::buf_entry_type)),
    .DEPTH (DEPTH),
    .CW    (3)
  ) u_queue (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .flush_i     (flush_all), // RULE13 RULE15 RULE16
    .in_valid_i  (push_mask),
    .in_data_i   ({q_in[1], q_in[0]}),
    .in_ready_o  (q_ready),
    .out_valid_o (issue_valid_o),
    .out_data_o  (issue_entry_o),
    .out_ready_i (issue_ready_i),
    .count_o     (q_count)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_buffer_bound: assert property (q_count <= 3'(DEPTH)) // RULE1
    else $error("buffer over four");
  a_full_holds: assert property ((q_count == 3'(DEPTH) && !flush_all &&
    state != pfu_pkg::FETCH_RETRY) |=> !fetch_req_o) // RULE24
    else $error("request while full");
  a_flush_refetch: assert property (flush_i |=> fetch_req_o &&
    fetch_addr_o == $past(flush_addr_i) && !issue_valid_o) // RULE13
    else $error("flush not refetched");
  a_recover_issue: assert property (flush_i ##1 !flush_all ##1
    (push_mask != 2'b00 && !flush_all) |=> issue_valid_o) // RULE18
    else $error("target not issued in cycle four");
  a_predict_gate: assert property (!predict_enable_i |->
    !pred_redirect && !link_write) // RULE7
    else $error("prediction while disabled");
  a_taken_redirect: assert property ((pred_redirect && !flush_all) |=>
    fetch_addr_o == $past(pred_target)) // RULE4
    else $error("taken branch not redirected");
  a_spec_hold: assert property ((state == pfu_pkg::FETCH_HOLD) |->
    !fetch_req_o) // RULE10
    else $error("fetch during speculative miss");
  a_link_entry: assert property ((link_write && !flush_all) |=>
    ret_valid && ret_addr == $past(link_pc)) // RULE8
    else $error("return entry not written");
  a_ret_mismatch: assert property ((ret_check_i && !flush_i &&
    link_value_i != ret_addr) |=> mispredict_o &&
    fetch_addr_o == $past(link_value_i)) // RULE20
    else $error("return mismatch not flushed");

  c_taken_spec:  cover property (pred_redirect && pred_spec);
  c_spec_hold:   cover property (state == pfu_pkg::FETCH_HOLD);
  c_phantom:     cover property (issue_valid_o && issue_entry_o.phantom);
  c_ret_miss:    cover property (mispredict_o);

endmodule // instruction_prefetch_branch_predict
`default_nettype wire

// ---- rtl/pfu_pkg.sv ----
`default_nettype none
package pfu_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned BUF_DEPTH = 4;
  localparam int unsigned LANES     = 2;
  localparam int unsigned CLK_NS    = 50;

  // ----------------------------------------
  // instruction encodings
  // ----------------------------------------
  localparam logic [31:0] BRANCH_MASK    = 32'h0e00_0000;
  localparam logic [31:0] BRANCH_MATCH   = 32'h0a00_0000;
  localparam logic [31:0] RETURN_MASK    = 32'h0fff_ffff;
  localparam logic [31:0] EXCH_RET_MATCH = 32'h012f_ff1e;
  localparam logic [31:0] MOVE_RET_MATCH = 32'h01a0_f00e;
  localparam int unsigned LINK_BIT       = 24;
  localparam int unsigned SIGN_BIT       = 23;
  localparam logic [3:0]  COND_ALWAYS    = 4'he;

  // ----------------------------------------
  // address arithmetic and reset values
  // ----------------------------------------
  localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
  localparam logic [31:0] DWORD_STEP = 32'h0000_0008;
  localparam logic [31:0] PC_AHEAD   = 32'h0000_0008;
  localparam logic [31:0] RESET_PC   = 32'h0000_0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FETCH_RUN   = 2'b00,
    FETCH_RETRY = 2'b01,
    FETCH_HOLD  = 2'b11
  } fetch_state_type;

  typedef enum logic [1:0] {
    KIND_PLAIN  = 2'b00,
    KIND_LINK   = 2'b01,
    KIND_RETURN = 2'b11
  } issue_kind_type;

  typedef struct packed {
    logic [31:0]    instr;
    logic [31:0]    pc;
    issue_kind_type kind;
    logic           abort;
    logic           phantom;
    logic [3:0]     phantom_cond;
    logic           pred_taken;
    logic [31:0]    alt_pc;
  } buf_entry_type;

  typedef struct packed {
    logic [63:0] data;
    logic        abort;
    logic [1:0]  bkpt;
    logic        miss;
  } fetch_resp_type;

endpackage
`default_nettype wire

// ---- rtl/prefetch_queue.sv ----
`timescale 1ns/10ps
`default_nettype none
module prefetch_queue #(
  parameter int unsigned WIDTH = 105,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned CW    = 3
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic             flush_i,
  // fill side, lane 0 first
  input  wire logic [1:0]       in_valid_i,
  input  wire logic [2*WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i,
  output logic [CW-1:0]         count_o
);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [CW-1:0]    next_count;
  logic [CW-1:0]    kept;
  logic             pop;

  // room for a whole doubleword
  assign in_ready_o = (count_o <= CW'(DEPTH - 2));
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem[0];

  // shift on pop, then place new lanes behind
  always_comb begin
    kept = count_o - CW'(pop);
    next_count = kept;
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = (pop && i + 1 < DEPTH) ? mem[i + 1] : mem[i];
      if (in_ready_o && in_valid_i[0] && CW'(i) == kept)
        next_mem[i] = in_data_i[WIDTH-1:0];
      if (in_ready_o && in_valid_i[1] && CW'(i) == kept + CW'(1))
        next_mem[i] = in_data_i[2*WIDTH-1:WIDTH];
    end
    if (in_ready_o)
      next_count = kept + CW'(in_valid_i[0]) + CW'(in_valid_i[1]);
  end

  // storage
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < DEPTH; i++)
      mem[i] <= next_mem[i];
  end

  // occupancy and head valid
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || flush_i) begin
      count_o     <= '0;
      out_valid_o <= 1'b0;
    end else begin
      count_o     <= next_count;
      out_valid_o <= (next_count != '0);
    end
  end

endmodule // prefetch_queue
`default_nettype wire

// ---- tb/imem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module imem_model (
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  // request from the prefetch side
  input  wire logic                   fetch_req_i,
  input  wire logic [31:0]            fetch_addr_i,
  input  wire logic                   fetch_spec_i,
  input  wire logic                   miss_spec_i,
  // response
  output logic                        fetch_valid_o,
  output var pfu_pkg::fetch_resp_type fetch_resp_o
);
  // ----------------------------------------
  // program image
  // ----------------------------------------
  logic [31:0] prog [0:255];
  logic [1:0]  bkpt_mask = 2'b00; // per-word breakpoint, set by the bench

  // plain non-branch words, the bench patches branches in
  initial begin
    for (int i = 0; i < 256; i++) begin
      prog[i] = 32'he3a0_0000 + 32'(i);
    end
  end

  // ----------------------------------------
  // one-cycle response
  // ----------------------------------------
  // answers each request at the next edge; idle data keeps toggling
  always_ff @(posedge mclk_i) begin
    fetch_valid_o      <= resetn_i & fetch_req_i;
    fetch_resp_o.abort <= 1'b0;
    fetch_resp_o.bkpt  <= bkpt_mask;
    fetch_resp_o.miss  <= fetch_req_i & fetch_spec_i & miss_spec_i;
    if (!resetn_i) begin
      fetch_resp_o.data <= 64'h0000_0000_0000_0000;
    end else if (fetch_req_i && !(fetch_spec_i && miss_spec_i)) begin
      fetch_resp_o.data <= {prog[{fetch_addr_i[9:3], 1'b1}],
                            prog[{fetch_addr_i[9:3], 1'b0}]};
    end else begin
      fetch_resp_o.data <= ~fetch_resp_o.data;
    end
  end
endmodule // imem_model
`default_nettype wire

// ---- tb/instruction_prefetch_branch_predict_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module instruction_prefetch_branch_predict_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                    mclk_i           = 1'b0;
  logic                    resetn_i         = 1'b0;
  logic                    predict_enable_i = 1'b0;
  logic                    code_state_i     = 1'b0;
  logic                    issue_ready_i    = 1'b0;
  logic                    flush_i          = 1'b0;
  logic [31:0]             flush_addr_i     = 32'h0000_0000;
  logic                    resolve_i        = 1'b0;
  logic                    ret_check_i      = 1'b0;
  logic [31:0]             link_value_i     = 32'h0000_0000;
  logic                    link_state_i     = 1'b0;
  logic                    miss_spec        = 1'b0;
  logic                    spec_seen        = 1'b0;
  logic                    fetch_req_o;
  logic [31:0]             fetch_addr_o;
  logic                    fetch_spec_o;
  logic                    fetch_valid_i;
  pfu_pkg::fetch_resp_type fetch_resp_i;
  logic                    issue_valid_o;
  pfu_pkg::buf_entry_type  issue_entry_o;
  logic                    mispredict_o;
  pfu_pkg::buf_entry_type  e;
  int                      fails     = 0;
  int                      tests_run = 0;
  int                      cycles    = 0;

  // ----------------------------------------
  // design, memory partner, clock, watchdog
  // ----------------------------------------
  instruction_prefetch_branch_predict DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i),
    .predict_enable_i(predict_enable_i), .code_state_i(code_state_i),
    .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
    .fetch_spec_o(fetch_spec_o), .fetch_valid_i(fetch_valid_i),
    .fetch_resp_i(fetch_resp_i), .issue_valid_o(issue_valid_o),
    .issue_entry_o(issue_entry_o), .issue_ready_i(issue_ready_i),
    .flush_i(flush_i), .flush_addr_i(flush_addr_i),
    .resolve_i(resolve_i), .ret_check_i(ret_check_i),
    .link_value_i(link_value_i), .link_state_i(link_state_i),
    .mispredict_o(mispredict_o));

  imem_model mem (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .fetch_req_i(fetch_req_o),
    .fetch_addr_i(fetch_addr_o), .fetch_spec_i(fetch_spec_o),
    .miss_spec_i(miss_spec), .fetch_valid_o(fetch_valid_i),
    .fetch_resp_o(fetch_resp_i));

  // free-running clock
  always #25 mclk_i = ~mclk_i;

  // watchdog and speculative request monitor
  always @(posedge mclk_i) begin
    cycles++;
    if (fetch_req_o === 1'b1 && fetch_spec_o === 1'b1) spec_seen <= 1'b1;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [31:0] plain(input logic [31:0] a);
    return 32'he3a0_0000 + {24'h00_0000, a[9:2]};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // takes the next issued entry into e, bounded wait
  task automatic pop();
    int n;
    n = 0;
    issue_ready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (issue_valid_o !== 1'b1 && n < 40);
    e = issue_entry_o;
    if (n >= 40) check(64'h0, 64'h1);
  endtask

  task automatic expect_pc(input logic [31:0] pc, input logic [31:0] ins);
    pop();
    check({e.pc, e.instr}, {pc, ins});
  endtask

  // core redirect with refetch timing
  task automatic redirect(input logic [31:0] a);
    @(posedge mclk_i);
    issue_ready_i <= 1'b0;
    flush_i       <= 1'b1;
    flush_addr_i  <= a;
    @(posedge mclk_i);
    flush_i <= 1'b0;
    #1;
    check({31'h0, fetch_req_o, fetch_addr_o}, {32'h1, a});
    check({63'h0, issue_valid_o}, 64'h0);
    @(posedge mclk_i);
    @(posedge mclk_i);
    #1;
    check({63'h0, issue_valid_o}, 64'h1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // stall until full, drain in order; odd word start
  task automatic t_stream();
    redirect(32'h0000_0000);
    repeat (12) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      expect_pc(32'(i * 4), plain(32'(i * 4)));
    end
    redirect(32'h0000_0014);
    expect_pc(32'h0000_0014, plain(32'h0000_0014));
    expect_pc(32'h0000_0018, plain(32'h0000_0018));
    $display("test stream done");
  endtask

  // backward loop, speculative miss waits for resolve
  task automatic t_backward();
    mem.prog[66] = 32'h1aff_fffc;
    predict_enable_i <= 1'b1;
    miss_spec        <= 1'b1;
    redirect(32'h0000_0100);
    expect_pc(32'h0000_0100, plain(32'h0000_0100));
    expect_pc(32'h0000_0104, plain(32'h0000_0104));
    repeat (10) @(posedge mclk_i);
    #1;
    check({61'h0, fetch_req_o, issue_valid_o, spec_seen}, 64'h1);
    @(posedge mclk_i);
    resolve_i <= 1'b1;
    @(posedge mclk_i);
    resolve_i <= 1'b0;
    miss_spec <= 1'b0;
    expect_pc(32'h0000_0100, plain(32'h0000_0100));
    check({58'h0, e.phantom, e.pred_taken, e.phantom_cond}, 64'h31);
    expect_pc(32'h0000_0104, plain(32'h0000_0104));
    $display("test backward done");
  endtask

  // forward branch dropped when enabled, plain on breakpoint or disabled
  task automatic t_forward();
    mem.prog[129] = 32'h1a00_0001;
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk_i);
      predict_enable_i <= (k < 2);
      mem.bkpt_mask    <= {k == 1, 1'b0};
      redirect(32'h0000_0200);
      expect_pc(32'h0000_0200, plain(32'h0000_0200));
      if (k == 0) begin
        expect_pc(32'h0000_0208, plain(32'h0000_0208));
        check({e.alt_pc, 26'h0, e.phantom, e.pred_taken, e.phantom_cond},
              {32'h0000_0210, 32'h21});
      end else begin
        expect_pc(32'h0000_0204, 32'h1a00_0001);
        check({63'h0, e.phantom}, 64'h0);
      end
    end
    $display("test forward done");
  endtask

  // call then leaf return one word into the callee, good and bad link
  task automatic t_call_return();
    int mp;
    mem.prog[192] = 32'heb00_0002;
    mem.prog[197] = 32'he12f_ff1e;
    predict_enable_i <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      redirect(32'h0000_0300);
      expect_pc(32'h0000_0300, 32'heb00_0002);
      check({62'h0, e.kind}, {62'h0, pfu_pkg::KIND_LINK});
      expect_pc(32'h0000_0310, plain(32'h0000_0310));
      expect_pc(32'h0000_0314, 32'he12f_ff1e);
      check({30'h0, e.kind, e.alt_pc},
            {30'h0, pfu_pkg::KIND_RETURN, 32'h0000_0304});
      expect_pc(32'h0000_0304, plain(32'h0000_0304));
      @(posedge mclk_i);
      issue_ready_i <= 1'b0;
      ret_check_i   <= 1'b1;
      link_state_i  <= 1'b1;
      link_value_i  <= (k == 0) ? 32'h0000_0304 : 32'h0000_0080;
      @(posedge mclk_i);
      ret_check_i <= 1'b0;
      mp = 0;
      repeat (4) begin
        #1;
        mp += (mispredict_o === 1'b1);
        @(posedge mclk_i);
      end
      check(64'(mp), 64'(k));
      if (k == 1) expect_pc(32'h0000_0080, plain(32'h0000_0080));
    end
    $display("test call return done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    resetn_i     <= 1'b1;
    code_state_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    t_stream();
    t_backward();
    t_forward();
    t_call_return();
    tally_and_finish();
  end
endmodule // instruction_prefetch_branch_predict_test
`default_nettype wire
